// ==== verilog/act_pkg.sv ====
// Constants, tables and types for the conversion timing controller.
// Assumes one 20 MHz system clock and an AHB-Lite master for registers.
package act_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG  = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_DATA = 8'h0c;
  // Oscillator rates in kHz against the system clock (20000 kHz).
  localparam logic [15:0] SYS_KHZ       = 16'h4e20;
  localparam logic [15:0] OSC_NORM_KHZ  = 16'h0400;
  localparam logic [15:0] OSC_TURBO_KHZ = 16'h0800;
  // Start delays in half oscillator cycles: 28.5 and 105 cycles.
  localparam logic [16:0] DLY_NORM_X2  = 17'h00039;
  localparam logic [16:0] DLY_TURBO_X2 = 17'h000d2;
  // Oscillator cycles per rate code 0..6, code 0 in the low slot.
  localparam logic [6:0][15:0] CONT_CYC = {16'h040c, 16'h06bc,
    16'h0c2c, 16'h171c, 16'h2d0c, 16'h58fc, 16'hc7f8};
  localparam logic [6:0][15:0] SS_NORM_CYC = {16'h0425, 16'h06d5,
    16'h0c45, 16'h1735, 16'h2d25, 16'h5915, 16'hc80d};
  localparam logic [6:0][15:0] SS_TURBO_CYC = {16'h0429, 16'h06d9,
    16'h0c49, 16'h1739, 16'h2d29, 16'h5919, 16'hc811};
  localparam logic [2:0] RATE_MAX = 3'h6;
  // Input select, reference and gain codes.
  localparam logic [3:0] MUX_MON_REF = 4'hc;
  localparam logic [3:0] MUX_MON_SUP = 4'hd;
  localparam logic [1:0] MUX_SE_TOP  = 2'h2;
  localparam logic [1:0] VREF_INT    = 2'h0;
  localparam logic [2:0] GAIN_X1     = 3'h0;
  localparam logic [2:0] GAIN_X4     = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV  = 3'b100
  } act_fsm_t;

  // Effective analog front-end controls.
  typedef struct packed {
    logic [1:0] refSel;
    logic [2:0] gain;
    logic       pgaBypass;
    logic [2:0] excitation_level;
    logic       excBias;
    logic [2:0] excitation1_route;
    logic [2:0] excitation2_route;
    logic       burnSource;
    logic       burnSink;
    logic       modActive;
    logic [2:0] filtRate;
  } act_afe_t;

  // Whole state of the controller.
  typedef struct packed {
    act_fsm_t    fsm;
    logic [15:0] acc;
    logic [16:0] cnt;
    logic        cont;
    logic        turbo;
    logic [2:0]  rate;
    logic [1:0]  vref;
    logic [2:0]  excLevel;
    logic [2:0]  ex1;
    logic [2:0]  ex2;
    logic        burnout_enable;
    logic [3:0]  input_select;
    logic [2:0]  gain;
    logic        pgaByp;
    logic        sleeping;
    logic        rdyN;
    logic        fallPend;
    logic [23:0] result;
    logic        dSel;
    logic        dWr;
    logic [7:0]  dAddr;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
    act_afe_t    afe;
  } act_regs_t;

  localparam act_regs_t REGS_RST = '{fsm: ST_IDLE, ready: 1'b1,
    rdyN: 1'b1, default: '0};
endpackage

// ==== verilog/act_ctrl.sv ====
// Conversion sequencer and analog configuration for a delta-sigma core.
// Assumes an AHB-Lite master on the register port and a filter that
// presents its latest word on filterResult.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
module act_ctrl #(
  parameter logic [15:0] SYS_KHZ = act_pkg::SYS_KHZ
) (
  input  logic                clk_sys,
  input  logic                srst,
  input  logic                hsel,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic [31:0]         hwdata,
  input  logic                hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  logic [23:0]         filterResult,
  output logic                result_ready_n,
  output act_pkg::act_afe_t   afeCtrl
);

  // State and its next value, then strobes that are decoded afresh each cycle.
  act_pkg::act_regs_t q;
  act_pkg::act_regs_t d;
  logic [16:0] sum;
  logic [16:0] step;
  logic        tick;
  logic        wrCtrl;
  logic        wrCfg;
  logic        start;
  logic        sleep_cmd;
  logic        rdClr;
  logic        mon;
  logic        singleEnd;

  // Conversion length in half cycles after the start delay.
  function automatic logic [16:0] convLen(
    input logic [2:0] rate,
    input logic       turbo,
    input logic       cont
  );
    logic [2:0]  r;
    logic [16:0] ss;
    // Rate code 7 has no table entry and runs as the fastest setting.
    r = (rate > act_pkg::RATE_MAX) ? act_pkg::RATE_MAX : rate;
    ss = turbo ? {act_pkg::SS_TURBO_CYC[r], 1'b0}
               : {act_pkg::SS_NORM_CYC[r], 1'b0};
    if (cont)
    begin
      convLen = {act_pkg::CONT_CYC[r], 1'b0};
    end
    else if (turbo)
    begin
      convLen = ss - act_pkg::DLY_TURBO_X2;
    end
    else
    begin
      convLen = ss - act_pkg::DLY_NORM_X2;
    end
  endfunction

  // Start delay in half cycles for the selected speed.
  function automatic logic [16:0] startDly(input logic turbo);
    startDly = turbo ? act_pkg::DLY_TURBO_X2
                     : act_pkg::DLY_NORM_X2;
  endfunction

  // Next-state logic for the bus slave, timebase and sequencer.
  always_comb
  begin
    d = q;
    // A fractional accumulator makes a half-cycle tick of the oscillator;
    // the system clock is no integer multiple, so ticks jitter by one
    // system cycle but never drift.
    // Turbo doubles the oscillator, so it also doubles the step.
    if (q.turbo)
    begin
      step = {act_pkg::OSC_TURBO_KHZ, 1'b0};
    end
    else
    begin
      step = {act_pkg::OSC_NORM_KHZ, 1'b0};
    end
    // Both terms stay below 2**16, so the 17-bit sum cannot wrap.
    sum = {1'b0, q.acc} + step;
    tick = 1'b0;
    if (sum >= {1'b0, SYS_KHZ})
    begin
      sum = sum - {1'b0, SYS_KHZ};
      tick = 1'b1;
    end
    d.acc = sum[15:0];

    // Address phase: latch the transfer, prepare read data.
    // Read data is registered so it stands in the data phase with no wait state.
    // Unmapped offsets read as zero and never disturb the ready flag.
    d.dSel = hsel & hready & htrans[1];
    d.dWr = hwrite;
    d.dAddr = haddr[7:0];
    d.rdata = 32'h00000000;
    rdClr = 1'b0;
    if (hsel & hready & htrans[1] & ~hwrite)
    begin
      if (haddr[7:0] == act_pkg::A_CTRL)
      begin
        d.rdata = {25'h0000000, q.rate, q.turbo, q.cont, 2'b00};
      end
      else if (haddr[7:0] == act_pkg::A_CFG)
      begin
        d.rdata = {12'h000, q.pgaByp, q.gain, q.input_select,
                   q.burnout_enable, q.ex2, q.ex1, q.excLevel, q.vref};
      end
      else if (haddr[7:0] == act_pkg::A_STAT)
      begin
        d.rdata = {27'h0000000, q.sleeping, q.fsm, ~q.rdyN};
      end
      else if (haddr[7:0] == act_pkg::A_DATA)
      begin
        d.rdata = {8'h00, q.result};
        rdClr = 1'b1;
      end
      else
      begin
        d.rdata = 32'h00000000;
      end
    end

    // Data phase: apply writes; command bits act once per write.
    // The target was kept from the address phase, as hwdata only arrives now.
    wrCtrl = q.dSel & q.dWr & (q.dAddr == act_pkg::A_CTRL);
    wrCfg = q.dSel & q.dWr & (q.dAddr == act_pkg::A_CFG);
    start = wrCtrl & hwdata[0];
    sleep_cmd = wrCtrl & hwdata[1];
    if (wrCtrl)
    begin
      d.cont = hwdata[2];
      d.turbo = hwdata[3];
      d.rate = hwdata[6:4];
    end
    // Configuration fields reach the front end on the same edge that stores them.
    if (wrCfg)
    begin
      d.vref = hwdata[1:0];
      d.excLevel = hwdata[4:2];
      d.ex1 = hwdata[7:5];
      d.ex2 = hwdata[10:8];
      d.burnout_enable = hwdata[11];
      d.input_select = hwdata[15:12];
      d.gain = hwdata[18:16];
      d.pgaByp = hwdata[19];
    end

    // Ready flag: a read clears it, but a pending or new result set
    // in the same cycle wins over the clear.
    if (rdClr)
    begin
      d.rdyN = 1'b1;
    end
    // A pending fall lowers the flag right after its forced one-cycle high.
    if (q.fallPend)
    begin
      d.rdyN = 1'b0;
      d.fallPend = 1'b0;
    end

    // Sequencer. Sleep beats a start written in the same word.
    // A start in any state restarts the delay, so software can resync at will.
    if (sleep_cmd)
    begin
      d.fsm = act_pkg::ST_IDLE;
      d.sleeping = 1'b1;
    end
    else if (start)
    begin
      d.fsm = act_pkg::ST_DELAY;
      d.cnt = startDly(d.turbo);
      d.sleeping = 1'b0;
      d.rdyN = 1'b1;
      d.fallPend = 1'b0;
    end
    else
    begin
      case (q.fsm)
        act_pkg::ST_IDLE:
        begin
          d.cnt = 17'h00000;
        end
        act_pkg::ST_DELAY:
        begin
          // Count down the start delay in half oscillator cycles.
          if (tick)
          begin
            if (q.cnt <= 17'h00001)
            begin
              d.fsm = act_pkg::ST_CONV;
              d.cnt = convLen(q.rate, q.turbo, q.cont);
            end
            else
            begin
              d.cnt = q.cnt - 17'h00001;
            end
          end
        end
        act_pkg::ST_CONV:
        begin
          // Count down one conversion, then store and flag the result.
          if (tick)
          begin
            if (q.cnt <= 17'h00001)
            begin
              // The filter settles in one period, so every word is kept.
              d.result = filterResult;
              // An unread result still low gets a one-cycle high so
              // every completion without an A_DATA read in the same cycle shows a falling edge.
              if (!d.rdyN)
              begin
                d.rdyN = 1'b1;
                d.fallPend = 1'b1;
              end
              else
              begin
                d.rdyN = 1'b0;
              end
              if (q.cont)
              begin
                d.cnt = convLen(q.rate, q.turbo, 1'b1);
              end
              else
              begin
                d.fsm = act_pkg::ST_IDLE;
              end
            end
            else
            begin
              d.cnt = q.cnt - 17'h00001;
            end
          end
        end
        default:
        begin
          d.fsm = act_pkg::ST_IDLE;
        end
      endcase
    end

    // Effective front-end settings, derived from the next configuration.
    mon = (d.input_select == act_pkg::MUX_MON_REF)
        | (d.input_select == act_pkg::MUX_MON_SUP);
    singleEnd = (d.input_select[3:2] == act_pkg::MUX_SE_TOP);
    // Stored fields stay untouched, so leaving a monitor code restores them.
    d.afe.refSel = mon ? act_pkg::VREF_INT : d.vref;
    if (mon)
    begin
      d.afe.gain = act_pkg::GAIN_X1;
    end
    else if (singleEnd && d.gain > act_pkg::GAIN_X4)
    begin
      d.afe.gain = act_pkg::GAIN_X4;
    end
    else
    begin
      d.afe.gain = d.gain;
    end
    d.afe.pgaBypass = mon | singleEnd | d.pgaByp;
    // Sleep drops bias and routes together, so no source is left half on.
    d.afe.excBias = (d.excLevel != 3'h0) & ~d.sleeping;
    d.afe.excitation_level = d.afe.excBias ? d.excLevel : 3'h0;
    d.afe.excitation1_route = d.afe.excBias ? d.ex1 : 3'h0;
    d.afe.excitation2_route = d.afe.excBias ? d.ex2 : 3'h0;
    d.afe.burnSource = d.burnout_enable;
    d.afe.burnSink = d.burnout_enable;
    d.afe.modActive = (d.fsm != act_pkg::ST_IDLE);
    d.afe.filtRate = d.rate;
    // Zero wait states and an OKAY response on every transfer.
    d.ready = 1'b1;
    d.resp = 1'b0;
  end

  // Single state register; reset is synchronous.
  // Reset values come from one constant, so state and outputs agree after it.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      q <= act_pkg::REGS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs taken straight from the state register.
  // No logic sits between the register and a pin, so outputs never glitch.
  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign result_ready_n = q.rdyN;
  assign afeCtrl = q.afe;

endmodule

// ==== dv/act_assertions.sv ====
// Port checker for the conversion sequencer and front-end controls.
// Assumes a bind onto act_ctrl, one clock and a synchronous active-high reset.
module act_checker #(
  parameter logic [15:0] SYS_KHZ = act_pkg::SYS_KHZ
) (
  input logic              clk_sys,
  input logic              srst,
  input logic              hsel,
  input logic [31:0]       haddr,
  input logic [1:0]        htrans,
  input logic              hwrite,
  input logic [31:0]       hwdata,
  input logic              hready,
  input logic              result_ready_n,
  input act_pkg::act_afe_t afeCtrl
);
  logic take;
  logic wrCtrl;
  logic wrCfg;
  logic contMode;
  assign take = hsel && hready && htrans[1];
  // Write data only stands one cycle after the address, so the target is kept.
  always_ff @(posedge clk_sys)
  begin
    wrCtrl <= !srst && take && hwrite && haddr[7:0] == act_pkg::A_CTRL;
    wrCfg <= !srst && take && hwrite && haddr[7:0] == act_pkg::A_CFG;
    contMode <= srst ? 1'b0 : (wrCtrl ? hwdata[2] : contMode);
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_dataRead;
    take && !hwrite && haddr[7:0] == act_pkg::A_DATA;
  endsequence
  sequence s_startWr;
    wrCtrl && hwdata[0] && !hwdata[1];
  endsequence
  property p_reset_ref;
    $fell(srst) |-> afeCtrl == '0 && result_ready_n;
  endproperty
  a_reset_ref: assert property (p_reset_ref)
    else $error("Front end left reset dirty.");
  property p_bias;
    afeCtrl.excBias == (afeCtrl.excitation_level != 3'h0);
  endproperty
  a_bias: assert property (p_bias)
    else $error("Bias does not follow level.");
  property p_route_off;
    afeCtrl.excitation_level == 3'h0 |-> afeCtrl.excitation1_route == 3'h0
      && afeCtrl.excitation2_route == 3'h0;
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("Route live with excitation off.");
  property p_start;
    s_startWr |-> ##[1:2] afeCtrl.modActive;
  endproperty
  a_start: assert property (p_start)
    else $error("Start did not wake the sequencer.");
  property p_sleep;
    wrCtrl && hwdata[1] |-> ##[1:2] !afeCtrl.modActive && afeCtrl.excitation_level == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleep left sources powered.");
  property p_monitor;
    wrCfg && hwdata[15:13] == 3'h6 |-> ##[1:2] afeCtrl.pgaBypass
      && afeCtrl.gain == act_pkg::GAIN_X1 && afeCtrl.refSel == act_pkg::VREF_INT;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("Monitor code not forced.");
  property p_read_clear;
    s_dataRead |=> result_ready_n;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Ready low after data read.");
  property p_cont_run;
    $fell(result_ready_n) && contMode |-> afeCtrl.modActive;
  endproperty
  a_cont_run: assert property (p_cont_run)
    else $error("Continuous run stopped.");
endmodule

bind act_ctrl act_checker #(.SYS_KHZ(SYS_KHZ)) act_checker_i (.clk_sys(clk_sys),
  .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .result_ready_n(result_ready_n), .afeCtrl(afeCtrl));

// ==== dv/act_host_model.sv ====
// Host side model: supplies filter words and times the ready output.
// Assumes the controller's system clock; it needs no reset of its own.
module act_host_model (
  input  logic        clk_sys,
  input  logic        result_ready_n,
  output logic [23:0] filterResult,
  output logic [15:0] gapClk
);
  logic        prevRdyN = 1'b1;
  logic [15:0] runClk = 16'h0;
  initial filterResult = 24'h5a3c1e;
  initial gapClk = 16'h0;
  // The word moves on after each result, so a stale store reads wrong.
  always @(posedge clk_sys)
  begin
    prevRdyN <= result_ready_n;
    runClk <= runClk + 16'h1;
    if (prevRdyN && !result_ready_n)
    begin
      gapClk <= runClk;
      runClk <= 16'h1;
      filterResult <= {filterResult[22:0], ~filterResult[23]};
    end
  end
endmodule

// ==== dv/adc_conversion_timing_ctrl_test.sv ====
// Self-checking bench for the conversion timing controller.
// Assumes act_pkg, act_ctrl, the checker and the host model are compiled.
module adc_conversion_timing_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SYSK = 4100;
  logic              clk_sys;
  logic              srst;
  logic              hsel;
  logic              hwrite;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              result_ready_n;
  logic [23:0]       filterResult;
  logic [15:0]       gapClk;
  act_pkg::act_afe_t afeCtrl;
  int                miscompares = 0;
  int                n_compared = 0;
  // A low divider rate keeps each conversion to a few thousand clocks.
  act_ctrl #(.SYS_KHZ(16'h1004)) act_ctrl_i (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .filterResult(filterResult), .result_ready_n(result_ready_n), .afeCtrl(afeCtrl));
  act_host_model act_host_model_i (.clk_sys(clk_sys), .result_ready_n(result_ready_n),
    .filterResult(filterResult), .gapClk(gapClk));

  task automatic close_out();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    close_out();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Clock counts carry a couple of clocks of divider jitter.
  function automatic logic [31:0] near(input int n, input int e);
    return (n > e - 4 && n < e + 4) ? 32'(e) : 32'(n);
  endfunction
  function automatic int clkFor(input int half, input int step);
    return (half * SYSK + step / 2) / step;
  endfunction
  task automatic edgeReady();
    int i;
    i = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
    begin
      if (++i > 20) timeout();
      @(posedge clk_sys);
    end
  endtask
  // One single transfer: address phase held to ready, then the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    edgeReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edgeReady();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic waitLow(inout int n);
    while (result_ready_n !== 1'b0)
    begin
      if (n > 9000) timeout();
      @(posedge clk_sys);
      n++;
    end
  endtask

  task automatic t_reset();
    chk(32'(afeCtrl), 32'h0);
    chk(32'(result_ready_n), 32'h1);
    rd(act_pkg::A_STAT, 32'h2);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_config();
    wr(act_pkg::A_CFG, 32'h320);
    chk(32'({afeCtrl.excBias, afeCtrl.excitation1_route, afeCtrl.excitation2_route}),
        32'h0);
    wr(act_pkg::A_CFG, 32'h0e);
    chk(32'({afeCtrl.refSel, afeCtrl.excitation_level, afeCtrl.excBias}), 32'h27);
    repeat (4000) @(posedge clk_sys);
    wr(act_pkg::A_CFG, 32'ha2e);
    chk(32'({afeCtrl.excitation1_route, afeCtrl.excitation2_route, afeCtrl.burnSource,
             afeCtrl.burnSink}), 32'h2b);
    for (int k = 12; k < 14; k++)
    begin
      wr(act_pkg::A_CFG, {12'h000, 4'h5, 4'(k), 12'h001});
      chk(32'({afeCtrl.refSel, afeCtrl.gain, afeCtrl.pgaBypass}), 32'h1);
    end
    wr(act_pkg::A_CFG, {12'h000, 4'h7, 4'h8, 12'h001});
    chk(32'({afeCtrl.refSel, afeCtrl.gain, afeCtrl.pgaBypass}), 32'h15);
    wr(act_pkg::A_CFG, 32'h2c);
    chk(32'({afeCtrl.burnSource, afeCtrl.burnSink, afeCtrl.refSel}), 32'h0);
    repeat (500) @(posedge clk_sys);
  endtask
  task automatic t_single(input logic tb_t);
    logic [23:0] expWord;
    int n;
    int e;
    n = 2;
    e = clkFor(tb_t ? 2130 : 2122, tb_t ? 4096 : 2048);
    expWord = filterResult;
    wr(act_pkg::A_CTRL, tb_t ? 32'h69 : 32'h61);
    waitLow(n);
    chk(near(n, e), 32'(e));
    rd(act_pkg::A_STAT, 32'h3);
    rd(act_pkg::A_DATA, {8'h0, expWord});
    chk(32'({result_ready_n, afeCtrl.modActive, afeCtrl.excitation_level,
             afeCtrl.filtRate}), 32'h9e);
  endtask
  task automatic t_cont(input logic tb_t);
    logic [23:0] expWord;
    int n;
    int step;
    int e;
    n = 2;
    step = tb_t ? 4096 : 2048;
    e = clkFor(tb_t ? 2282 : 2129, step);
    expWord = filterResult;
    wr(act_pkg::A_CTRL, tb_t ? 32'h6d : 32'h65);
    waitLow(n);
    chk(near(n, e), 32'(e));
    rd(act_pkg::A_DATA, {8'h0, expWord});
    waitLow(n);
    repeat (2) @(posedge clk_sys);
    e = clkFor(2072, step);
    chk(near(int'(gapClk), e), 32'(e));
    wr(act_pkg::A_CTRL, 32'h3);
    chk(32'({afeCtrl.modActive, afeCtrl.excitation_level}), 32'h0);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    srst = 1'b1;
    hsize = 3'h2;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_config();
    t_single(1'b0);
    t_single(1'b1);
    t_cont(1'b0);
    t_cont(1'b1);
    close_out();
  end
endmodule
